// [hdl/sbc_spi_defines.vh]
/*
 Constants for the SPI register map block: addresses, reset value,
 field positions, mode codes and frame figures.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef SBC_SPI_DEFINES_VH
`define SBC_SPI_DEFINES_VH

// Frame layout
`define FRAME_BITS 5'h10
`define CNT_SAT 5'h11
`define ACCESS_BIT 7
`define PEEK_CNT 5'h07

// Address windows
`define CTRL_LO 7'h01
`define CTRL_HI 7'h1E
`define STAT_LO 7'h41
`define STAT_HI 7'h7E

// Special status addresses
`define ADDR_WAKE_LEVEL 7'h48
`define ADDR_FAMILY_ID 7'h7E

// Control register addresses
`define ADDR_MODE_SUPPLY 7'h01
`define ADDR_HARDWARE 7'h02
`define ADDR_WATCHDOG 7'h03
`define ADDR_BUS_FIRST 7'h04
`define ADDR_BUS_SECOND 7'h05
`define ADDR_WAKE_FIRST 7'h06
`define ADDR_WAKE_SECOND 7'h07
`define ADDR_WAKE_PULL 7'h08
`define ADDR_CYCLIC_TIMER 7'h0C
`define ADDR_SCRATCH 7'h1E

// Clearable status register addresses
`define ADDR_SUPPLY_STAT 7'h41
`define ADDR_THERMAL_STAT 7'h42
`define ADDR_DEVICE_STAT 7'h43
`define ADDR_BUS_FAIL_FIRST 7'h44
`define ADDR_BUS_FAIL_SECOND 7'h45
`define ADDR_WAKE_SRC_FIRST 7'h46
`define ADDR_WAKE_SRC_SECOND 7'h47
`define ADDR_SWITCHER_STAT 7'h4C

// Reset value of every register
`define REG_RESET 8'h00

// Mode supply and hardware control fields
`define MODE_LSB 6
`define SUP2_LSB 3
`define FO_ON_BIT 5

// Transceiver field codes and positions
`define TRX_ON 2'h3
`define TRX_WAKE 2'h1
`define TRX_LO_LSB 0
`define TRX_HI_LSB 3

// Mode field codes
`define MODEF_NORMAL 2'h0
`define MODEF_SLEEP 2'h1
`define MODEF_STOP 2'h2

// Second supply enable codes
`define SUP2_NORMAL 2'h1
`define SUP2_STOP 2'h2
`define SUP2_ALL 2'h3

// Operating mode codes on opMode
`define OPM_NORMAL 3'h0
`define OPM_STOP 3'h1
`define OPM_SLEEP 3'h2
`define OPM_RESTART 3'h3
`define OPM_FAILSAFE 3'h4
`define OPM_INIT 3'h5

`endif

// [hdl/spi_frame_shifter.v]
/*
 SPI frame engine: synchronises the pins, shifts commands in on the
 falling clock edge and answers out after the rising edge, LSB first.
 Assumes the register side supplies readByte for the peeked address.
*/
`timescale 1ns/1ps
`include "sbc_spi_defines.vh"

module spi_frame_shifter
(
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// SPI pins
	input wire csN,
	input wire sclk,
	input wire sdi,
	output reg sdo,
	output reg sdoOe,
	// Register side
	input wire [7:0] readByte,
	input wire [7:0] infoByte,
	output reg [15:0] cmdWord,
	output reg frameValid
);

////////////////////////////////////////////////////////////////////////
reg [2:0] csSyncQ;
reg [2:0] clkSyncQ;
reg [1:0] sdiSyncQ;
reg [4:0] cntQ;
reg [15:0] txQ;
reg errQ;
reg badEdgeQ;
wire csFall = csSyncQ[2] & ~csSyncQ[1];
wire csRise = ~csSyncQ[2] & csSyncQ[1];
wire sckRise = ~clkSyncQ[2] & clkSyncQ[1];
wire sckFall = clkSyncQ[2] & ~clkSyncQ[1];
wire active = ~csSyncQ[1];
wire cntOk = (cntQ == `FRAME_BITS) | (cntQ == 5'h00);

// Two-stage synchronisers plus an edge stage
always @(posedge ref_clk)
begin
	if (srst)
	begin
		csSyncQ <= 3'h7;
		clkSyncQ <= 3'h0;
		sdiSyncQ <= 2'h0;
	end
	else
	begin
		csSyncQ <= {csSyncQ[1:0], csN};
		clkSyncQ <= {clkSyncQ[1:0], sclk};
		sdiSyncQ <= {sdiSyncQ[0], sdi};
	end
end

// Shift, count and judge the frame
always @(posedge ref_clk)
begin
	if (srst)
	begin
		cntQ <= 5'h00;
		cmdWord <= 16'h0000;
		txQ <= 16'h0000;
		sdo <= 1'b0;
		sdoOe <= 1'b0;
		errQ <= 1'b0;
		badEdgeQ <= 1'b0;
		frameValid <= 1'b0;
	end
	else
	begin
		frameValid <= 1'b0;
		sdoOe <= active;
		if (csFall)
		begin
			cntQ <= 5'h00;
			txQ <= {8'h00, infoByte};
			sdo <= errQ;
			badEdgeQ <= clkSyncQ[1];
		end
		else if (csRise)
		begin
			frameValid <= cntQ == `FRAME_BITS && !badEdgeQ && !clkSyncQ[1];
			errQ <= !cntOk | badEdgeQ | clkSyncQ[1];
		end
		else if (active)
		begin
			if (sckRise)
			begin
				sdo <= txQ[0];
				txQ <= {1'b0, txQ[15:1]};
			end
			if (sckFall)
			begin
				cmdWord <= {sdiSyncQ[1], cmdWord[15:1]};
				if (cntQ != `CNT_SAT)
					cntQ <= cntQ + 5'h01;
				if (cntQ == `PEEK_CNT)
					txQ[7:0] <= readByte;
			end
		end
	end
end

endmodule

// [hdl/sbc_spi_register_map.v]
/*
 SPI register map of a system basis chip: command decode, control
 and status registers, mode driven field updates.
 Assumes opMode and status events come from logic on ref_clk and the
 SPI pins and wake pin come from outside this clock domain.
*/
`timescale 1ns/1ps
`include "sbc_spi_defines.vh"

module sbc_spi_register_map
#(
	parameter [7:0] FAMILY_ID = 8'h5A, // Arbitrary identity value
	parameter CTRL_NUM = 10,
	parameter STAT_NUM = 8
)
(
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// SPI pins
	input wire csN,
	input wire sclk,
	input wire sdi,
	output wire sdo,
	output wire sdoOe,
	// Device state
	input wire [2:0] opMode,
	input wire [63:0] statusEvents,
	input wire wakePin,
	input wire cfg2State,
	input wire testMode,
	input wire failTrigger,
	// Register outputs
	output reg [79:0] ctrlFlat,
	output reg [7:0] statusInfo,
	output reg [1:0] modeRequest,
	output reg modeRequestStb,
	output reg secondSupplyOn,
	output reg failOutputs
);

////////////////////////////////////////////////////////////////////////
// Address and mask tables

function [6:0] ctrlAddr;
	input integer idx;
	reg [3:0] sel;
	begin
		sel = idx[3:0];
		case (sel)
			4'h0: ctrlAddr = `ADDR_MODE_SUPPLY;
			4'h1: ctrlAddr = `ADDR_HARDWARE;
			4'h2: ctrlAddr = `ADDR_WATCHDOG;
			4'h3: ctrlAddr = `ADDR_BUS_FIRST;
			4'h4: ctrlAddr = `ADDR_BUS_SECOND;
			4'h5: ctrlAddr = `ADDR_WAKE_FIRST;
			4'h6: ctrlAddr = `ADDR_WAKE_SECOND;
			4'h7: ctrlAddr = `ADDR_WAKE_PULL;
			4'h8: ctrlAddr = `ADDR_CYCLIC_TIMER;
			default: ctrlAddr = `ADDR_SCRATCH;
		endcase
	end
endfunction

// Implemented bits per control register
function [7:0] ctrlMask;
	input integer idx;
	reg [3:0] sel;
	begin
		sel = idx[3:0];
		case (sel)
			4'h0: ctrlMask = 8'hDF;
			4'h1: ctrlMask = 8'hFF;
			4'h2: ctrlMask = 8'hFF;
			4'h3: ctrlMask = 8'hFB;
			4'h4: ctrlMask = 8'h1B;
			4'h5: ctrlMask = 8'h44;
			4'h6: ctrlMask = 8'h01;
			4'h7: ctrlMask = 8'h03;
			4'h8: ctrlMask = 8'h07;
			default: ctrlMask = 8'hFF;
		endcase
	end
endfunction

function [6:0] statAddr;
	input integer idx;
	reg [3:0] sel;
	begin
		sel = idx[3:0];
		case (sel)
			4'h0: statAddr = `ADDR_SUPPLY_STAT;
			4'h1: statAddr = `ADDR_THERMAL_STAT;
			4'h2: statAddr = `ADDR_DEVICE_STAT;
			4'h3: statAddr = `ADDR_BUS_FAIL_FIRST;
			4'h4: statAddr = `ADDR_BUS_FAIL_SECOND;
			4'h5: statAddr = `ADDR_WAKE_SRC_FIRST;
			4'h6: statAddr = `ADDR_WAKE_SRC_SECOND;
			default: statAddr = `ADDR_SWITCHER_STAT;
		endcase
	end
endfunction

// Implemented bits per clearable status register
function [7:0] statMask;
	input integer idx;
	reg [3:0] sel;
	begin
		sel = idx[3:0];
		case (sel)
			4'h0: statMask = 8'hFD;
			4'h1: statMask = 8'h07;
			4'h2: statMask = 8'hFF;
			4'h3: statMask = 8'h67;
			4'h4: statMask = 8'h1E;
			4'h5: statMask = 8'hB1;
			4'h6: statMask = 8'h07;
			default: statMask = 8'hF7;
		endcase
	end
endfunction

// Turn ON transceiver fields into wake capable
function [7:0] sleepTrx;
	input [7:0] val;
	reg [7:0] res;
	begin
		res = val;
		if (val[`TRX_LO_LSB+:2] == `TRX_ON)
			res[`TRX_LO_LSB+:2] = `TRX_WAKE;
		if (val[`TRX_HI_LSB+:2] == `TRX_ON)
			res[`TRX_HI_LSB+:2] = `TRX_WAKE;
		sleepTrx = res;
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Frame engine

wire [15:0] cmdWord;
wire frameValid;
reg [7:0] readByte;

spi_frame_shifter uShifter
(
	.ref_clk(ref_clk),
	.srst(srst),
	.csN(csN),
	.sclk(sclk),
	.sdi(sdi),
	.sdo(sdo),
	.sdoOe(sdoOe),
	.readByte(readByte),
	.infoByte(statusInfo),
	.cmdWord(cmdWord),
	.frameValid(frameValid)
);

// Command fields
wire [6:0] cmdAddr = cmdWord[6:0];
wire cmdAccess = cmdWord[`ACCESS_BIT];
wire [7:0] cmdData = cmdWord[15:8];
wire [6:0] peekAddr = cmdWord[15:9];

////////////////////////////////////////////////////////////////////////
// Mode tracking

reg [2:0] opModeQ;
reg [1:0] wakeSyncQ;
reg failLatchQ;
wire modeChanged = opMode != opModeQ;
wire enterSleep = modeChanged && opMode == `OPM_SLEEP;
wire isNormal = opMode == `OPM_NORMAL;
wire deaf = opMode == `OPM_RESTART || opMode == `OPM_SLEEP ||
	opMode == `OPM_FAILSAFE;
wire cmdOk = frameValid && !deaf;
wire inCtrl = cmdAddr >= `CTRL_LO && cmdAddr <= `CTRL_HI;
wire inStat = cmdAddr >= `STAT_LO && cmdAddr <= `STAT_HI;
wire ctrlWrite = cmdOk && cmdAccess && inCtrl;
wire statClear = cmdOk && cmdAccess && inStat;

// Mode code for the field, unchanged for other modes
reg [1:0] modeField;
reg modeFieldHit;
always @*
begin
	modeFieldHit = 1'b1;
	case (opMode)
		`OPM_NORMAL: modeField = `MODEF_NORMAL;
		`OPM_SLEEP: modeField = `MODEF_SLEEP;
		`OPM_STOP: modeField = `MODEF_STOP;
		default:
		begin
			modeField = `MODEF_NORMAL;
			modeFieldHit = 1'b0;
		end
	endcase
end

// Mode history, wake pin sync and fail latch
always @(posedge ref_clk)
begin
	if (srst)
	begin
		opModeQ <= `OPM_INIT;
		wakeSyncQ <= 2'h0;
		failLatchQ <= 1'b0;
	end
	else
	begin
		opModeQ <= opMode;
		wakeSyncQ <= {wakeSyncQ[0], wakePin};
		if (failTrigger)
			failLatchQ <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////
// Control registers

wire [79:0] ctrlD;
genvar g;
generate
	for (g = 0; g < CTRL_NUM; g = g + 1)
	begin : gCtrl
		reg [7:0] nx;
		wire [7:0] cur = ctrlFlat[g*8+:8];
		wire hit = ctrlWrite && cmdAddr == ctrlAddr(g);
		always @*
		begin
			nx = cur;
			if (hit)
				nx = cmdData & ctrlMask(g);
			if (hit && g == 0 && !isNormal)
				nx[`SUP2_LSB+:2] = cur[`SUP2_LSB+:2];
			if (g == 0 && modeChanged && modeFieldHit)
				nx[`MODE_LSB+:2] = modeField;
			if ((g == 3 || g == 4) && enterSleep)
				nx = sleepTrx(nx);
		end
		assign ctrlD[g*8+:8] = nx;
	end
endgenerate

// Store control registers, issue mode requests
always @(posedge ref_clk)
begin
	if (srst)
	begin
		ctrlFlat <= {10{`REG_RESET}};
		modeRequest <= `MODEF_NORMAL;
		modeRequestStb <= 1'b0;
		secondSupplyOn <= 1'b0;
		failOutputs <= 1'b0;
	end
	else
	begin
		ctrlFlat <= ctrlD;
		modeRequestStb <= ctrlWrite && cmdAddr == `ADDR_MODE_SUPPLY;
		if (ctrlWrite && cmdAddr == `ADDR_MODE_SUPPLY)
			modeRequest <= cmdData[`MODE_LSB+:2];
		case (ctrlFlat[`SUP2_LSB+:2])
			`SUP2_NORMAL: secondSupplyOn <= isNormal;
			`SUP2_STOP: secondSupplyOn <= isNormal ||
				opMode == `OPM_STOP;
			`SUP2_ALL: secondSupplyOn <= isNormal ||
				opMode == `OPM_STOP || opMode == `OPM_SLEEP;
			default: secondSupplyOn <= 1'b0;
		endcase
		failOutputs <= failLatchQ | ctrlFlat[8+`FO_ON_BIT];
	end
end

////////////////////////////////////////////////////////////////////////
// Status registers

reg [63:0] statFlat;
wire [63:0] statD;
generate
	for (g = 0; g < STAT_NUM; g = g + 1)
	begin : gStat
		wire clr = statClear && cmdAddr == statAddr(g);
		wire [7:0] kept = clr ? 8'h00 : statFlat[g*8+:8];
		// Set wins over a clear in the same cycle
		assign statD[g*8+:8] = (kept | statusEvents[g*8+:8]) &
			statMask(g);
	end
endgenerate

// Store status and summary field
always @(posedge ref_clk)
begin
	if (srst)
	begin
		statFlat <= 64'h0000000000000000;
		statusInfo <= 8'h00;
	end
	else
	begin
		statFlat <= statD;
		statusInfo <= {|statD[63:56], |statD[55:48], |statD[47:40],
			|statD[39:32], |statD[31:24], |statD[23:16],
			|statD[15:8], |statD[7:0]};
	end
end

////////////////////////////////////////////////////////////////////////
// Read data for the address being received

// Live wake level byte, never stored
wire [7:0] wakeLevel = {testMode, 1'b0, cfg2State, 4'h0,
	wakeSyncQ[1]};

integer k;
always @*
begin
	readByte = 8'h00;
	for (k = 0; k < CTRL_NUM; k = k + 1)
		if (peekAddr == ctrlAddr(k))
			readByte = ctrlFlat[k*8+:8];
	for (k = 0; k < STAT_NUM; k = k + 1)
		if (peekAddr == statAddr(k))
			readByte = statFlat[k*8+:8];
	if (peekAddr == `ADDR_WAKE_LEVEL)
		readByte = wakeLevel;
	if (peekAddr == `ADDR_FAMILY_ID)
		readByte = FAMILY_ID;
end

endmodule

// [tb/sbc_spi_checker.sv]
/*
 Checker on the register map ports.
 Assumes a bind to the top module of the design.
*/
`timescale 1ns/1ps
module sbc_spi_checker
(
	// Watched ports
	input wire ref_clk,
	input wire srst,
	input wire csN,
	input wire [2:0] opMode,
	input wire [63:0] statusEvents,
	input wire failTrigger,
	input wire [79:0] ctrlFlat,
	input wire [7:0] statusInfo,
	input wire sdoOe,
	input wire modeRequestStb,
	input wire secondSupplyOn,
	input wire failOutputs
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Status summary, mode fields, fail outputs, frozen map
	a_info_set: assert property (
		(statusEvents[7:0] & 8'hFD) != 8'h00 |-> ##[1:3] statusInfo[0])
		else $error("summary flag not set");
	a_info_clear: assert property (
		$fell(statusInfo[0]) |-> csN)
		else $error("summary flag fell during a frame");
	a_mode_stop: assert property (
		$changed(opMode) && opMode == 3'h1 |-> ##[1:2] ctrlFlat[7:6] == 2'h2)
		else $error("mode field not stop");
	a_mode_norm: assert property (
		$changed(opMode) && opMode == 3'h0 |-> ##[1:2] ctrlFlat[7:6] == 2'h0)
		else $error("mode field not normal");
	a_sleep_trx: assert property (
		$changed(opMode) && opMode == 3'h2 && ctrlFlat[25:24] == 2'h3
		|-> ##[1:2] ctrlFlat[25:24] == 2'h1)
		else $error("transceiver field not wake capable");
	a_fail_trig: assert property (
		failTrigger |-> ##[1:2] failOutputs)
		else $error("fail outputs not set");
	a_fail_sleep: assert property (
		failOutputs && opMode == 3'h2 |=> failOutputs)
		else $error("fail outputs dropped in sleep");
	a_map_frozen: assert property (
		opMode == 3'h2 && $past(opMode, 3) == 3'h2 |=> $stable(ctrlFlat))
		else $error("control changed in sleep");
	a_req_pulse: assert property (
		modeRequestStb |=> !modeRequestStb)
		else $error("mode request strobe longer than one cycle");
	a_oe_select: assert property (
		$fell(csN) |-> ##[2:4] sdoOe)
		else $error("output enable not raised in frame");
	a_supply_stop: assert property (
		opMode == 3'h1 && $stable(opMode) && ctrlFlat[4:3] == 2'h1
		|=> !secondSupplyOn)
		else $error("second supply on in stop");
endmodule

// [tb/spi_host_model.sv]
/*
 Host model: sends frames of n bits LSB first, captures the answer.
 Assumes sclk idles low and frames are aligned to ref_clk.
*/
`timescale 1ns/1ps
module spi_host_model
(
	// Link side
	input wire ref_clk,
	input wire sdo,
	input wire sdoOe,
	output reg csN,
	output reg sclk,
	output reg sdi
);
	// Idle levels
	initial
	begin
		csN = 1;
		sclk = 0;
		sdi = 0;
	end
	// Released line shows the inverse of the last driven bit
	wire sdoLine = sdoOe ? sdo : ~sdo;
	// Frame of n clocks; r holds answer bits above the error bit
	task xfer(input [15:0] c, input [4:0] n, output [16:0] r);
		integer i;
	begin
		@(posedge ref_clk) #1;
		csN = 0;
		#80 r[0] = sdoLine;
		for (i = 0; i < n; i = i + 1)
		begin
			sdi = c[i];
			sclk = 1;
			#40 sclk = 0;
			#35 r[i + 1] = sdoLine;
			#5;
		end
		csN = 1;
		sdi = ~sdi;
		#100;
	end
	endtask
endmodule

// [tb/test_sbc_spi_register_map.sv]
/*
 Bench for the register map: host frames, mode and status stimulus.
 Assumes the host model and checker are compiled first.
*/
`timescale 1ns/1ps
module test_sbc_spi_register_map;
	reg ref_clk = 0, srst = 1, failTrigger = 0;
	reg wakePin = 1, cfg2State = 0, testMode = 1;
	reg [2:0] opMode = 3'h0;
	reg [63:0] statusEvents = 64'h0;
	reg [16:0] r;
	wire csN, sclk, sdi, sdo, sdoOe, failOutputs;
	wire [1:0] modeRequest;
	wire modeRequestStb, secondSupplyOn;
	integer nStb = 0;
	integer n_mismatch = 0, tests_run = 0;
	// Clock and parts
	always #5 ref_clk = ~ref_clk;
	spi_host_model host (.ref_clk(ref_clk), .sdo(sdo), .sdoOe(sdoOe),
		.csN(csN), .sclk(sclk), .sdi(sdi));
	// Count one-cycle mode request strobes
	always @(posedge ref_clk)
		if (modeRequestStb)
			nStb <= nStb + 1;
	sbc_spi_register_map DUT (.ref_clk(ref_clk), .srst(srst), .csN(csN),
		.sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .opMode(opMode),
		.statusEvents(statusEvents), .wakePin(wakePin),
		.cfg2State(cfg2State), .testMode(testMode),
		.failTrigger(failTrigger), .ctrlFlat(), .statusInfo(),
		.modeRequest(modeRequest), .modeRequestStb(modeRequestStb),
		.secondSupplyOn(secondSupplyOn),
		.failOutputs(failOutputs));
	// Step past edges
	task tick(input integer n);
	begin
		repeat (n) @(posedge ref_clk);
		#1;
	end
	endtask
	// Compare one item
	task chk(input [7:0] nm, input [7:0] e, input [7:0] s);
	begin
		tests_run = tests_run + 1;
		if (s !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] item %h expected %h seen %h", nm, e, s);
		end
	end
	endtask
	// One command, answer data byte compared
	task cmd(input [6:0] a, input w, input [7:0] d, input [7:0] e);
	begin
		host.xfer({d, w, a}, 5'h10, r);
		chk({1'b0, a}, e, r[16:9]);
	end
	endtask
	// Verdict
	task conclude;
	begin
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	// Cut a hang short
	initial
	begin
		#200000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
	// Test sequence
	initial
	begin
		tick(6);
		srst = 0;
		tick(4);
		cmd(7'h01, 0, 8'hFF, 8'h00);
		cmd(7'h04, 1, 8'hFF, 8'h00);
		cmd(7'h04, 0, 8'h00, 8'hFB);
		cmd(7'h1E, 1, 8'hA5, 8'h00);
		cmd(7'h1F, 1, 8'h3C, 8'h00);
		cmd(7'h1F, 0, 8'h00, 8'h00);
		host.xfer(16'h119E, 5'hF, r);
		cmd(7'h1E, 0, 8'h00, 8'hA5);
		chk(8'hEE, 8'h01, {7'h0, r[0]});
		statusEvents[7:0] = 8'h83;
		tick(1);
		statusEvents = 64'h0;
		cmd(7'h41, 0, 8'h00, 8'h81);
		chk(8'hF0, 8'h01, r[8:1]);
		cmd(7'h41, 1, 8'h00, 8'h81);
		cmd(7'h41, 0, 8'h00, 8'h00);
		chk(8'hF0, 8'h00, r[8:1]);
		cmd(7'h48, 1, 8'h00, 8'h81);
		wakePin = 0;
		cfg2State = 1;
		cmd(7'h48, 0, 8'h00, 8'hA0);
		cmd(7'h7E, 0, 8'h00, 8'h5A);
		cmd(7'h01, 1, 8'h08, 8'h00);
		chk(8'hF4, 8'h01, {7'h0, secondSupplyOn});
		opMode = 3'h1;
		tick(3);
		chk(8'hF4, 8'h00, {7'h0, secondSupplyOn});
		cmd(7'h01, 1, 8'h98, 8'h88);
		chk(8'hF2, 8'h02, {6'h0, modeRequest});
		failTrigger = 1;
		tick(1);
		failTrigger = 0;
		opMode = 3'h2;
		tick(3);
		host.xfer(16'h0084, 5'h10, r);
		chk(8'hF1, 8'h01, {7'h0, failOutputs});
		opMode = 3'h3;
		tick(3);
		host.xfer(16'h0084, 5'h10, r);
		opMode = 3'h4;
		tick(3);
		host.xfer(16'hFF85, 5'h10, r);
		opMode = 3'h0;
		tick(3);
		cmd(7'h04, 0, 8'h00, 8'hE9);
		cmd(7'h05, 0, 8'h00, 8'h00);
		cmd(7'h01, 0, 8'h00, 8'h08);
		cmd(7'h01, 1, 8'h18, 8'h08);
		opMode = 3'h1;
		tick(3);
		chk(8'hF4, 8'h01, {7'h0, secondSupplyOn});
		cmd(7'h01, 0, 8'h00, 8'h98);
		chk(8'hF3, 8'h03, nStb[7:0]);
		conclude;
	end
endmodule
bind sbc_spi_register_map sbc_spi_checker chk (.ref_clk(ref_clk),
	.srst(srst), .csN(csN), .opMode(opMode), .statusEvents(statusEvents),
	.failTrigger(failTrigger), .ctrlFlat(ctrlFlat),
	.statusInfo(statusInfo), .sdoOe(sdoOe),
	.modeRequestStb(modeRequestStb), .secondSupplyOn(secondSupplyOn),
	.failOutputs(failOutputs));
